// [rtl/adcs_sequencer.sv]
// conversion sequencer: walks eight slots, drives the front end, stores results
// assumes register port and front end run on core_clk; serial engine decodes the bus
`timescale 1ns/100ps
`default_nettype none

module adcs_sequencer #(
    parameter int UNIT_CYCLES     = adcs_pkg::CONV_UNIT_CYC,
    parameter int HALF_SEC_CYCLES = adcs_pkg::HALF_SEC_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        conv_enable,
    input  wire logic        accum_enable,
    input  wire logic [3:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        adc_sign,
    input  wire logic [14:0] adc_magnitude,
    output logic             conv_active,
    output logic      [2:0]  active_slot,
    output logic      [2:0]  adc_mux_sel,
    output logic             adc_ref_single,
    output logic      [2:0]  adc_res_code,
    output logic             adc_input_short,
    output logic             thermistor_src_en,
    output logic      [31:0] charge_total,
    output logic      [31:0] discharge_total,
    output logic      [31:0] charge_timer,
    output logic      [31:0] discharge_timer
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // magnitude bits kept for a resolution code, left-aligned
    function automatic logic [14:0] mag_mask(input logic [2:0] code);
        mag_mask = 15'h7FFF << (4'h7 - {1'b0, code});
    endfunction

    function automatic logic [15:0] fmt_result(input logic        sign,
                                               input logic [14:0] raw,
                                               input logic [2:0]  code);
        logic [14:0] shifted;
        shifted    = raw << (4'h7 - {1'b0, code});
        fmt_result = {sign, shifted & mag_mask(code)};
    endfunction

    if (HALF_SEC_CYCLES < 2 || UNIT_CYCLES < 1)
    begin : g_check
        $error("timing parameters out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]          slot_cfg    [adcs_pkg::NUM_SLOTS];
    logic [15:0]         result_mem  [adcs_pkg::NUM_SLOTS];
    logic [7:0]          cur_cfg;
    adcs_pkg::adcs_state_t state;
    logic                slot_en;
    logic                conv_start;
    logic                timer_done;
    logic                timer_busy;
    logic                result_we;
    logic [15:0]         next_result;
    logic [31:0]         tick_count;
    logic                half_tick;
    logic [7:0]          pick_cfg;
    logic [2:0]          pick_sel;

    assign slot_en     = slot_cfg[active_slot][adcs_pkg::CFG_EN_BIT];
    assign conv_start  = (state == adcs_pkg::ADCS_PICK) && conv_enable && slot_en;
    assign result_we   = (state == adcs_pkg::ADCS_CONV) && conv_enable && timer_done;
    assign next_result = fmt_result(adc_sign, adc_magnitude,
                                    cur_cfg[adcs_pkg::CFG_RES_MSB:adcs_pkg::CFG_RES_LSB]);
    assign pick_cfg    = slot_cfg[active_slot];
    assign pick_sel    = pick_cfg[adcs_pkg::CFG_SEL_MSB:adcs_pkg::CFG_SEL_LSB];

    // config bytes written over the serial engine; reserved slot stays zero
    for (genvar i = 0; i < adcs_pkg::NUM_SLOTS; i++)
    begin : g_cfg
        always_ff @(posedge core_clk)
        begin
            if (!rst_n)
            begin
                slot_cfg[i] <= adcs_pkg::CFG_RESET;
            end
            else if (reg_wr && reg_addr == adcs_pkg::REG_CFG_BASE + 4'(i)
                     && 3'(i) != adcs_pkg::SLOT_RSVD)
            begin
                slot_cfg[i] <= reg_wdata;
            end
        end

        always_ff @(posedge core_clk)
        begin
            if (!rst_n)
            begin
                result_mem[i] <= adcs_pkg::RESULT_RESET;
            end
            else if (result_we && active_slot == 3'(i))
            begin
                result_mem[i] <= next_result;
            end
        end
    end

    // read data, one cycle after the read strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            if (reg_addr >= adcs_pkg::REG_RES_BASE)
            begin
                reg_rdata <= result_mem[reg_addr[2:0]];
            end
            else
            begin
                reg_rdata <= {8'h00, slot_cfg[reg_addr[2:0]]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slot walk

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state       <= adcs_pkg::ADCS_IDLE;
            active_slot <= adcs_pkg::SLOT_CURRENT;
            cur_cfg     <= adcs_pkg::CFG_RESET;
        end
        else
        begin
            case (state)
                adcs_pkg::ADCS_IDLE:
                begin
                    active_slot <= adcs_pkg::SLOT_CURRENT;
                    if (conv_enable)
                    begin
                        state <= adcs_pkg::ADCS_PICK;
                    end
                end
                adcs_pkg::ADCS_PICK:
                begin
                    if (!conv_enable)
                    begin
                        state <= adcs_pkg::ADCS_IDLE;
                    end
                    else if (slot_en)
                    begin
                        cur_cfg <= slot_cfg[active_slot];
                        state   <= adcs_pkg::ADCS_CONV;
                    end
                    else
                    begin
                        active_slot <= active_slot + 3'h1;
                    end
                end
                adcs_pkg::ADCS_CONV:
                begin
                    if (!conv_enable)
                    begin
                        state <= adcs_pkg::ADCS_IDLE;
                    end
                    else if (timer_done)
                    begin
                        active_slot <= active_slot + 3'h1;
                        state       <= adcs_pkg::ADCS_PICK;
                    end
                end
                default:
                begin
                    state <= adcs_pkg::ADCS_IDLE;
                end
            endcase
        end
    end

    adcs_conv_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (conv_start),
        .abort    (!conv_enable),
        .res_code (slot_cfg[active_slot][adcs_pkg::CFG_RES_MSB:adcs_pkg::CFG_RES_LSB]),
        .busy     (timer_busy),
        .done     (timer_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // front-end controls, held for the whole conversion

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            conv_active       <= 1'b0;
            adc_mux_sel       <= adcs_pkg::SRC_CURRENT;
            adc_ref_single    <= 1'b0;
            adc_res_code      <= 3'h0;
            adc_input_short   <= 1'b0;
            thermistor_src_en <= 1'b0;
        end
        else if (conv_start)
        begin
            conv_active       <= 1'b1;
            adc_mux_sel       <= pick_sel;
            adc_ref_single    <= pick_cfg[adcs_pkg::CFG_REF_BIT];
            adc_res_code      <= pick_cfg[adcs_pkg::CFG_RES_MSB:adcs_pkg::CFG_RES_LSB];
            adc_input_short   <= pick_sel == adcs_pkg::SRC_ZERO;
            thermistor_src_en <= pick_sel == adcs_pkg::SRC_THERM;
        end
        else if (result_we || !conv_enable)
        begin
            conv_active       <= 1'b0;
            adc_input_short   <= 1'b0;
            thermistor_src_en <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // half-second totals fed from slot 0

    assign half_tick = (tick_count == 32'(HALF_SEC_CYCLES - 1));

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || half_tick)
        begin
            tick_count <= 32'h00000000;
        end
        else
        begin
            tick_count <= tick_count + 32'h00000001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            charge_total    <= 32'h00000000;
            discharge_total <= 32'h00000000;
            charge_timer    <= 32'h00000000;
            discharge_timer <= 32'h00000000;
        end
        else if (half_tick && accum_enable)
        begin
            if (!result_mem[adcs_pkg::SLOT_CURRENT][adcs_pkg::RESULT_SIGN_BIT])
            begin
                charge_total <= charge_total
                                + {17'h00000, result_mem[adcs_pkg::SLOT_CURRENT][14:0]};
                charge_timer <= charge_timer + 32'h00000001;
            end
            else
            begin
                discharge_total <= discharge_total
                                   + {17'h00000, result_mem[adcs_pkg::SLOT_CURRENT][14:0]};
                discharge_timer <= discharge_timer + 32'h00000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    therm_src_window_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        thermistor_src_en |-> conv_active && adc_mux_sel == adcs_pkg::SRC_THERM)
        else $error("thermistor source on outside its conversion");
    zero_short_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        conv_active |-> adc_input_short == (adc_mux_sel == adcs_pkg::SRC_ZERO))
        else $error("input short does not match zero source");
    skip_disabled_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == adcs_pkg::ADCS_PICK && conv_enable && !slot_en)
        |=> state == adcs_pkg::ADCS_PICK && active_slot == $past(active_slot) + 3'h1)
        else $error("disabled slot not skipped");
    start_enabled_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        conv_start |=> state == adcs_pkg::ADCS_CONV && conv_active && timer_busy)
        else $error("enabled slot not converted");
    slot_order_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        result_we |=> active_slot == $past(active_slot) + 3'h1
                      && state == adcs_pkg::ADCS_PICK)
        else $error("slot order broken");
    result_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        result_we |=> result_mem[$past(active_slot)] == $past(next_result))
        else $error("result not stored in own slot");
    result_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(result_we && active_slot == adcs_pkg::SLOT_CURRENT) |=> $stable(result_mem[0]))
        else $error("result changed without conversion");
    low_bits_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        result_we |-> (next_result[14:0] & ~mag_mask(adc_res_code)) == 15'h0000)
        else $error("unused magnitude bits not zero");
    ref_held_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        conv_active |-> adc_ref_single == cur_cfg[adcs_pkg::CFG_REF_BIT])
        else $error("reference mode not held");
    charge_add_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (half_tick && accum_enable && !result_mem[0][15])
        |=> charge_total == $past(charge_total) + {17'h00000, $past(result_mem[0][14:0])})
        else $error("charge total not updated");

endmodule

`default_nettype wire

// [rtl/adcs_pkg.sv]
// constants and types shared by the conversion sequencer files
// assumes a single 10 MHz core clock and a register port fed by the serial engine
package adcs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // slot layout
    localparam int          NUM_SLOTS       = 8;
    localparam int          CFG_EN_BIT      = 7;
    localparam int          CFG_RES_MSB     = 6;
    localparam int          CFG_RES_LSB     = 4;
    localparam int          CFG_REF_BIT     = 3;
    localparam int          CFG_SEL_MSB     = 2;
    localparam int          CFG_SEL_LSB     = 0;
    localparam int          RES_BASE_BITS   = 8;
    localparam int          MAG_BITS        = 15;
    localparam int          RESULT_SIGN_BIT = 15;

    // input-select codes
    localparam logic [2:0]  SRC_CURRENT     = 3'h0;
    localparam logic [2:0]  SRC_DIE_TEMP    = 3'h1;
    localparam logic [2:0]  SRC_THERM       = 3'h2;
    localparam logic [2:0]  SRC_PACK        = 3'h3;
    localparam logic [2:0]  SRC_RSVD        = 3'h4;
    localparam logic [2:0]  SRC_SPARE       = 3'h5;
    localparam logic [2:0]  SRC_ZERO        = 3'h6;

    // slot numbers
    localparam logic [2:0]  SLOT_CURRENT    = 3'h0;
    localparam logic [2:0]  SLOT_DIE_TEMP   = 3'h1;
    localparam logic [2:0]  SLOT_THERM      = 3'h2;
    localparam logic [2:0]  SLOT_PACK       = 3'h3;
    localparam logic [2:0]  SLOT_RSVD       = 3'h4;
    localparam logic [2:0]  SLOT_SPARE      = 3'h5;
    localparam logic [2:0]  SLOT_ZERO       = 3'h6;
    localparam logic [2:0]  SLOT_EXTRA      = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // register port offsets: configs at base plus slot, results likewise
    localparam logic [3:0]  REG_CFG_BASE    = 4'h0;
    localparam logic [3:0]  REG_RES_BASE    = 4'h8;
    localparam logic [7:0]  CFG_RESET       = 8'h00;
    localparam logic [15:0] RESULT_RESET    = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          OSC_NOMINAL_HZ  = 131072;
    localparam int          CONV_UNIT_NS    = 30520;
    localparam int          CONV_UNIT_CYC   = (CONV_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          HALF_SEC_MS     = 500;
    localparam int          HALF_SEC_CYC    = HALF_SEC_MS * (1000000 / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_PICK,
        ADCS_CONV
    } adcs_state_t;

endpackage

// [rtl/adcs_conv_timer.sv]
// conversion timer: counts unit * 2^(N+1) cycles, N = resolution code + 8
// assumes start is a one-cycle pulse and abort may arrive at any time
`timescale 1ns/100ps
`default_nettype none

module adcs_conv_timer #(
    parameter int UNIT_CYCLES = adcs_pkg::CONV_UNIT_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [2:0] res_code,
    output logic            busy,
    output logic            done
);

    logic [31:0] count;
    logic [31:0] target;
    logic [2:0]  code_held;

    if (UNIT_CYCLES < 1 || UNIT_CYCLES > 32767)
    begin : g_check
        $error("conversion unit out of range");
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            busy   <= 1'b0;
            count  <= 32'h00000000;
            target <= 32'h00000000;
            code_held <= 3'h0;
        end
        else if (abort)
        begin
            busy  <= 1'b0;
            count <= 32'h00000000;
        end
        else if (start)
        begin
            busy   <= 1'b1;
            count  <= 32'h00000000;
            target <= 32'(UNIT_CYCLES) << (5'(res_code) + 5'(adcs_pkg::RES_BASE_BITS + 1));
            code_held <= res_code;
        end
        else if (done)
        begin
            busy  <= 1'b0;
            count <= 32'h00000000;
        end
        else if (busy)
        begin
            count <= count + 32'h00000001;
        end
    end

    assign done = busy && !abort && (count == target - 32'h00000001);

    conv_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done |-> count == (32'(UNIT_CYCLES)
                           << (5'(code_held) + 5'(adcs_pkg::RES_BASE_BITS + 1))) - 32'h00000001)
        else $error("conversion length wrong");

    start_busy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (start && !abort) |=> busy && count == 32'h00000000)
        else $error("timer did not start");

endmodule

`default_nettype wire

// [test/adcs_front_end_model.sv]
// behavioural model of the analog front end behind the sequencer
// assumes controls are stable for the whole conversion; output is meaningful only then
`timescale 1ns/100ps
`default_nettype none

module adcs_front_end_model (
    input  wire logic        core_clk,
    input  wire logic        conv_active,
    input  wire logic [2:0]  adc_mux_sel,
    input  wire logic [2:0]  adc_res_code,
    input  wire logic        adc_input_short,
    input  wire logic        neg_input,
    output logic             adc_sign,
    output logic      [14:0] adc_magnitude
);
    logic [14:0] raw;
    logic [15:0] idle_pat = 16'h5AA5;

    ////////////////////////////////////////////////////////////////////////////
    // grounded input still shows a small converter offset
    always_comb
    begin
        raw = adc_input_short ? 15'h0003 : 15'h7ABC + 15'(adc_mux_sel);
        raw = raw & 15'((16'h0001 << (adc_res_code + 4'h8)) - 16'h0001);
    end

    // outside a conversion the lines wander every cycle
    always_ff @(posedge core_clk)
        idle_pat <= ~idle_pat;

    assign adc_sign      = conv_active ? (neg_input && adc_mux_sel == 3'h0)
                                       : idle_pat[15];
    assign adc_magnitude = conv_active ? raw : idle_pat[14:0];
endmodule

`default_nettype wire

// [test/adcs_sequencer_tb.sv]
// self-checking bench for the conversion sequencer
// assumes shortened unit and half-second counts, front end from the partner model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module adcs_sequencer_tb;
    logic        core_clk;
    logic        rst_n;
    logic        conv_enable;
    logic        accum_enable;
    logic [3:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [15:0] reg_rdata;
    logic        adc_sign;
    logic [14:0] adc_magnitude;
    logic        conv_active;
    logic [2:0]  active_slot;
    logic [2:0]  adc_mux_sel;
    logic        adc_ref_single;
    logic [2:0]  adc_res_code;
    logic        adc_input_short;
    logic        thermistor_src_en;
    logic [31:0] charge_total;
    logic [31:0] discharge_total;
    logic [31:0] charge_timer;
    logic [31:0] discharge_timer;
    logic        neg_input;
    logic [15:0] rd_val;
    logic [27:0] rows [9];
    int          n_mismatch;
    int          num_checks;
    int          cyc = 0;

    adcs_sequencer #(.UNIT_CYCLES(1), .HALF_SEC_CYCLES(50)) adcs_sequencer_i (
        .core_clk(core_clk), .rst_n(rst_n), .conv_enable(conv_enable),
        .accum_enable(accum_enable), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .adc_sign(adc_sign), .adc_magnitude(adc_magnitude), .conv_active(conv_active),
        .active_slot(active_slot), .adc_mux_sel(adc_mux_sel),
        .adc_ref_single(adc_ref_single), .adc_res_code(adc_res_code),
        .adc_input_short(adc_input_short), .thermistor_src_en(thermistor_src_en),
        .charge_total(charge_total), .discharge_total(discharge_total),
        .charge_timer(charge_timer), .discharge_timer(discharge_timer));

    adcs_front_end_model adcs_front_end_model_i (
        .core_clk(core_clk), .conv_active(conv_active), .adc_mux_sel(adc_mux_sel),
        .adc_res_code(adc_res_code), .adc_input_short(adc_input_short),
        .neg_input(neg_input), .adc_sign(adc_sign), .adc_magnitude(adc_magnitude));

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        tick(1);
        reg_wr    = 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] q);
        reg_addr = a;
        reg_rd   = 1'b1;
        tick(1);
        reg_rd   = 1'b0;
        tick(1);
        q        = reg_rdata;
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
        reg_read(a, rd_val);
        `CHK(rd_val, e)
    endtask

    // expected stored word: left-aligned magnitude under the sign
    function automatic logic [15:0] exp_res(input logic [2:0] sel, input logic [2:0] code,
                                            input logic s);
        logic [14:0] raw;
        raw = (sel == 3'h6) ? 15'h0003 : 15'h7ABC + 15'(sel);
        raw = raw & 15'((16'h0001 << (code + 4'h8)) - 16'h0001);
        return {s, 15'(raw << (4'h7 - code))};
    endfunction

    // one conversion: controls, duration, optional half-second totals check
    task automatic conv(input logic [2:0] sl, input logic [2:0] sel, input logic rf,
                        input logic [2:0] code, input int acc, input logic [31:0] m);
        int          n;
        logic [31:0] c0;
        logic [31:0] d0;
        logic [31:0] t0;
        logic [31:0] u0;
        n = 0;
        while (conv_active !== 1'b1)
            tick(1);
        `CHK(active_slot, sl)
        `CHK(adc_mux_sel, sel)
        `CHK(adc_ref_single, rf)
        `CHK(adc_res_code, code)
        `CHK(thermistor_src_en, sel == 3'h2)
        `CHK(adc_input_short, sel == 3'h6)
        while (conv_active === 1'b1)
        begin
            if (n == 100)
            begin
                c0 = charge_total;
                d0 = discharge_total;
                t0 = charge_timer;
                u0 = discharge_timer;
            end
            if (n == 150 && acc == 1)
            begin
                `CHK(charge_total - c0, m)
                `CHK(charge_timer - t0, 32'h1)
                `CHK(discharge_total, d0)
            end
            if (n == 150 && acc == 2)
            begin
                `CHK(discharge_total - d0, m)
                `CHK(discharge_timer - u0, 32'h1)
                `CHK(charge_total, c0)
            end
            n++;
            tick(1);
        end
        `CHK(n, 2 ** (code + 9))
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_mismatch   = 0;
        num_checks   = 0;
        rst_n        = 1'b0;
        conv_enable  = 1'b0;
        accum_enable = 1'b1;
        reg_addr     = 4'h0;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        reg_wdata    = 8'h00;
        neg_input    = 1'b0;
        // {index, write data, read-back}
        rows[0] = {4'h0, 8'h80, 16'h0080};
        rows[1] = {4'h1, 8'h7F, 16'h007F};
        rows[2] = {4'h2, 8'h8A, 16'h008A};
        rows[3] = {4'h3, 8'h4B, 16'h004B};
        rows[4] = {4'h4, 8'hFF, 16'h0000};
        rows[5] = {4'h5, 8'h05, 16'h0005};
        rows[6] = {4'h6, 8'h96, 16'h0096};
        rows[7] = {4'h7, 8'h07, 16'h0007};
        rows[8] = {4'h8, 8'hFF, 16'h0000};
        tick(16);
        rst_n = 1'b1;
        foreach (rows[i])
        begin
            reg_write(rows[i][27:24], rows[i][23:16]);
            reg_read(rows[i][27:24], rd_val);
            `CHK(rd_val, rows[i][15:0])
        end
        // one full cycle plus slots 0 and 2 of the second, slot 0 changes sign on the second
        conv_enable = 1'b1;
        conv(3'h0, 3'h0, 1'b0, 3'h0, 0, 32'h0);
        conv(3'h2, 3'h2, 1'b1, 3'h0, 1, 32'h5E00);
        neg_input = 1'b1;
        conv(3'h6, 3'h6, 1'b0, 3'h1, 0, 32'h0);
        conv(3'h0, 3'h0, 1'b0, 3'h0, 0, 32'h0);
        conv(3'h2, 3'h2, 1'b1, 3'h0, 2, 32'h5E00);
        // abort in mid-conversion
        while (conv_active !== 1'b1)
            tick(1);
        tick(20);
        conv_enable = 1'b0;
        tick(2);
        `CHK(conv_active, 1'b0)
        `CHK(adc_input_short, 1'b0)
        chk_reg(4'h8, exp_res(3'h0, 3'h0, 1'b1));
        chk_reg(4'h9, 16'h0000);
        chk_reg(4'hA, exp_res(3'h2, 3'h0, 1'b0));
        chk_reg(4'hC, 16'h0000);
        chk_reg(4'hE, exp_res(3'h6, 3'h1, 1'b0));
        // second reset in mid-run clears everything
        rst_n = 1'b0;
        tick(16);
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++)
            chk_reg(4'(i), 16'h0000);
        `CHK(charge_total, 32'h0)
        end_sim();
    end
endmodule

`default_nettype wire
